// *** logic/hdmfm_pkg.sv ***
// constants, register map and mfm helpers for the drive-side disk interface
package hdmfm_pkg;
	////////////////////////////////////////////////////////////////////////
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TXD = 8'h08;
	localparam logic [7:0] A_RXD = 8'h0C;
	localparam logic [7:0] A_POS = 8'h10;
	localparam logic [7:0] A_CRC = 8'h14;
	localparam logic [7:0] A_ID = 8'h18;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int C_READY = 0;
	localparam int C_RDEN = 1;
	localparam int C_ADDR = 2;
	localparam int C_FCLR = 4;
	localparam int TX_MARK = 8;
	////////////////////////////////////////////////////////////////////////
	// pin vector layout, idle levels of the pins
	localparam int P_WG = 0;
	localparam int P_HS = 1;
	localparam int P_STEP = 4;
	localparam int P_DIR = 5;
	localparam int P_DS = 6;
	localparam int P_WDP = 10;
	localparam int P_WDN = 11;
	localparam int NPIN = 12;
	localparam logic [11:0] PIN_IDLE = 12'hBFF;
	////////////////////////////////////////////////////////////////////////
	// geometry and timing
	localparam logic [8:0] CYL_MAX = 9'h131;
	localparam int CLK_NS = 100;
	localparam int CLK_MHZ = 10;
	localparam int REV_US = 16667;
	localparam int INDEX_US = 200;
	localparam int SETTLE_US = 1000;
	localparam int HALF_NS = 100;
	localparam int REV_CYC = REV_US * CLK_MHZ;
	localparam int INDEX_CYC = INDEX_US * CLK_MHZ;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int HALF_CYC = (HALF_NS / CLK_NS < 1) ? 1 : HALF_NS / CLK_NS;
	////////////////////////////////////////////////////////////////////////
	// mfm framing and check
	localparam logic [15:0] SYNC_MFM = 16'h4489;
	localparam logic [7:0] MARK_BYTE = 8'hA1;
	localparam logic [7:0] ID_MARK = 8'hFE;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam int MISS_BIT = 2;
	localparam logic [2:0] ID_FE = 3'h1;
	localparam logic [2:0] ID_FIRST = 3'h2;
	localparam logic [2:0] ID_LASTF = 3'h5;
	localparam logic [2:0] ID_END = 3'h7;

	typedef enum logic {RX_HUNT = 1'b0, RX_FRAME = 1'b1} hdmfm_rx_t;

	// one byte into 16 half cells, clock half first
	function automatic logic [15:0] hdmfm_enc(input logic [7:0] d, input logic prev, input logic mark);
		logic [15:0] p;
		logic last;
		p = '0;
		last = prev;
		for (int i = 7; i >= 0; i--) begin
			p[2*i+1] = ~d[i] & ~last & ~(mark && i == MISS_BIT);
			p[2*i] = d[i];
			last = d[i];
		end
		return p;
	endfunction : hdmfm_enc

	function automatic logic [7:0] hdmfm_data(input logic [15:0] r);
		logic [7:0] d;
		d = '0;
		for (int i = 0; i < 8; i++) begin
			d[i] = r[2*i];
		end
		return d;
	endfunction : hdmfm_data

	function automatic logic [15:0] hdmfm_crc(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction : hdmfm_crc
endpackage : hdmfm_pkg

// *** logic/hdmfm_drive.sv ***
// drive-side control, status and mfm data logic with an apb register port
//
// What this block does
// - the drive returns seek complete, track zero, write fault, index and ready.
// - the drive returns a drive-selected line beside the data pairs.
// - write data come in and read data go out as complementary mfm pairs.
// - a clock transition appears only when neither this nor the previous cell holds a one.
// - clock transitions sit at the start of a cell, data transitions at its middle.
// - every sector id is unique on the drive.
// - an id field holds a mark, cylinder, head, sector and check bytes.
// - formatted fields are checked with a crc made by the formatting and reading logic.
// - framing and data recovery tolerate about 3% speed deviation either way.
// - one index pulse is given per revolution.
// - track zero is asserted while the heads sit on cylinder zero.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module hdmfm_drive import hdmfm_pkg::*; #(
	parameter int REV_CYC_P = REV_CYC,
	parameter int SETTLE_CYC_P = SETTLE_CYC,
	parameter int HALF_CYC_P = HALF_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// control lines from the controller
	input wire logic wr_gate_n,
	input wire logic [2:0] head_sel_n,
	input wire logic step_n,
	input wire logic dir_in_n,
	input wire logic [3:0] drv_sel_in_n,
	// status lines to the controller
	output logic seek_cmpl_n,
	output logic track0_n,
	output logic wr_fault_n,
	output logic index_n,
	output logic ready_n,
	output logic drv_selected_n,
	// mfm data pairs
	input wire logic wr_data_p,
	input wire logic wr_data_n,
	output logic rd_data_p,
	output logic rd_data_n
);
	localparam int RW = $clog2(REV_CYC_P + 1);
	localparam int SW = $clog2(SETTLE_CYC_P + 1);
	localparam int HW = $clog2(HALF_CYC_P + 1);

	logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
	logic [31:0] ctrl_q;
	logic [8:0] cyl_q;
	logic [SW-1:0] settle_q;
	logic [RW-1:0] rev_q;
	logic step_prev_q, flt_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q, rdata_w;
	logic hit_w;
	logic [8:0] buf_q [2];
	logic buf_wp_q, buf_rp_q;
	logic [1:0] buf_cnt_q;
	logic [HW-1:0] enc_cnt_q;
	logic [3:0] enc_hx_q;
	logic [15:0] enc_pat_q, new_pat;
	logic enc_prev_q, rd_p_q, rd_n_q;
	logic [15:0] tx_crc_q, rx_crc_q;
	logic [HW-1:0] dec_cnt_q;
	logic [15:0] raw_q, raw_n;
	logic t_hold_q, wd_prev_q;
	hdmfm_rx_t rx_st_q;
	logic [3:0] rx_hx_q;
	logic [2:0] rx_idx_q;
	logic dec_prev_q;
	logic [8:0] rx_byte_q;
	logic rx_val_q, rx_ovr_q, mfm_err_q, id_fe_q, id_ok_q, id_match_q;
	logic [31:0] id_sh_q;
	logic [4:0] stat_q;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, a change counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
			pin_q <= PIN_IDLE;
		end else begin
			s1_q <= {wr_data_n, wr_data_p, drv_sel_in_n, dir_in_n, step_n, head_sel_n, wr_gate_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
		end
	end

	logic [1:0] drv_addr;
	logic sel, wg, ready_w, seek_done, index_w, step_edge, trans;
	logic [2:0] head;
	assign drv_addr = ctrl_q[C_ADDR+:2];
	assign sel = ~pin_q[P_DS + int'(drv_addr)];
	assign wg = sel & ~pin_q[P_WG];
	assign head = ~pin_q[P_HS+:3];
	assign step_edge = sel & ~pin_q[P_STEP] & step_prev_q;
	assign ready_w = ctrl_q[C_READY];
	assign seek_done = settle_q == '0;
	assign index_w = ready_w & (rev_q < RW'(INDEX_CYC));

	////////////////////////////////////////////////////////////////////////
	// apb slave, answer one cycle into the access phase
	logic acc, fire, hold;
	assign acc = psel & penable;
	assign hold = pwrite & (paddr == A_TXD) & (buf_cnt_q == 2'h2);
	assign fire = acc & pready_q;

	always_comb begin
		rdata_w = '0;
		hit_w = 1'b1;
		case (paddr)
			A_CTRL: rdata_w = ctrl_q;
			A_STAT: rdata_w = {19'h0, wg, rx_st_q == RX_FRAME, index_w, rx_ovr_q, mfm_err_q, id_match_q, id_ok_q,
				rx_val_q, buf_cnt_q == 2'h2, flt_q, seek_done, cyl_q == '0, sel};
			A_TXD: rdata_w = '0;
			A_RXD: rdata_w = {22'h0, rx_val_q, rx_byte_q};
			A_POS: rdata_w = {13'h0, head, 7'h0, cyl_q};
			A_CRC: rdata_w = {rx_crc_q, tx_crc_q};
			A_ID: rdata_w = id_sh_q;
			default: hit_w = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= acc & ~pready_q & ~hold;
			if (acc & ~pready_q & ~hold) begin
				pslverr_q <= ~hit_w;
				prdata_q <= pwrite ? 32'h0000_0000 : rdata_w;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RST;
		end else if (fire & pwrite & (paddr == A_CTRL)) begin
			ctrl_q <= {pwdata[31:C_FCLR+1], 1'b0, pwdata[C_FCLR-1:0]};
		end
	end

	logic fclr;
	assign fclr = fire & pwrite & (paddr == A_CTRL) & pwdata[C_FCLR];

	////////////////////////////////////////////////////////////////////////
	// head position, seek settle, index
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			step_prev_q <= 1'b1;
			cyl_q <= '0;
		end else begin
			step_prev_q <= pin_q[P_STEP];
			if (step_edge & ~pin_q[P_DIR] & (cyl_q != CYL_MAX)) begin
				cyl_q <= cyl_q + 9'h001;
			end else if (step_edge & pin_q[P_DIR] & (cyl_q != '0)) begin
				cyl_q <= cyl_q - 9'h001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			settle_q <= '0;
		end else if (step_edge) begin
			settle_q <= SW'(SETTLE_CYC_P);
		end else if (settle_q != '0) begin
			settle_q <= settle_q - SW'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rev_q <= '0;
		end else if (!ready_w || rev_q == RW'(REV_CYC_P - 1)) begin
			rev_q <= '0;
		end else begin
			rev_q <= rev_q + RW'(1);
		end
	end

	// write while not ready or still settling is a fault, set wins over clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flt_q <= 1'b0;
		end else begin
			flt_q <= (wg & (~ready_w | ~seek_done)) | (flt_q & ~fclr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status pins, asserted low and only while this drive is selected
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stat_q <= '1;
			drv_selected_n <= 1'b1;
		end else begin
			stat_q <= ~({sel & ready_w, sel & index_w, sel & flt_q, sel & (cyl_q == '0), sel & seek_done});
			drv_selected_n <= ~sel;
		end
	end
	assign seek_cmpl_n = stat_q[0];
	assign track0_n = stat_q[1];
	assign wr_fault_n = stat_q[2];
	assign index_n = stat_q[3];
	assign ready_n = stat_q[4];

	////////////////////////////////////////////////////////////////////////
	// two-entry transmit buffer, full stalls the apb write
	logic buf_push, buf_pop, enc_on, enc_tick, enc_load;
	assign buf_push = fire & pwrite & (paddr == A_TXD);
	assign buf_pop = enc_load & (buf_cnt_q != 2'h0);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			buf_wp_q <= 1'b0;
			buf_rp_q <= 1'b0;
			buf_cnt_q <= 2'h0;
		end else begin
			buf_wp_q <= buf_wp_q ^ buf_push;
			buf_rp_q <= buf_rp_q ^ buf_pop;
			buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (buf_push) begin
			buf_q[buf_wp_q] <= pwdata[TX_MARK:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mfm encoder toward the read pair
	logic [7:0] nxt_byte;
	logic nxt_mark;
	assign enc_on = ctrl_q[C_RDEN] & sel & ~wg & ready_w;
	assign enc_tick = enc_on & (enc_cnt_q == HW'(HALF_CYC_P - 1));
	assign enc_load = enc_tick & (enc_hx_q == 4'hF);
	assign nxt_byte = (buf_cnt_q != 2'h0) ? buf_q[buf_rp_q][7:0] : FILL_BYTE;
	assign nxt_mark = (buf_cnt_q != 2'h0) & buf_q[buf_rp_q][TX_MARK];
	assign new_pat = hdmfm_enc(nxt_byte, enc_prev_q, nxt_mark);

	// both halves of the pair registered so neither output passes a gate
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			enc_cnt_q <= '0;
			enc_hx_q <= 4'hF;
			enc_pat_q <= '0;
			enc_prev_q <= 1'b0;
			rd_p_q <= 1'b0;
			rd_n_q <= 1'b1;
		end else if (!enc_on) begin
			enc_cnt_q <= '0;
			enc_hx_q <= 4'hF;
			enc_pat_q <= '0;
			enc_prev_q <= 1'b0;
			rd_p_q <= 1'b0;
			rd_n_q <= 1'b1;
		end else begin
			enc_cnt_q <= enc_tick ? '0 : enc_cnt_q + HW'(1);
			rd_p_q <= 1'b0;
			rd_n_q <= 1'b1;
			if (enc_load) begin
				enc_pat_q <= {new_pat[14:0], 1'b0};
				rd_p_q <= new_pat[15];
				rd_n_q <= ~new_pat[15];
				enc_prev_q <= nxt_byte[0];
				enc_hx_q <= 4'h0;
			end else if (enc_tick) begin
				enc_pat_q <= {enc_pat_q[14:0], 1'b0};
				rd_p_q <= enc_pat_q[15];
				rd_n_q <= ~enc_pat_q[15];
				enc_hx_q <= enc_hx_q + 4'h1;
			end
		end
	end
	assign rd_data_p = rd_p_q;
	assign rd_data_n = rd_n_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_crc_q <= CRC_INIT;
		end else if (buf_pop) begin
			tx_crc_q <= hdmfm_crc(nxt_mark ? CRC_INIT : tx_crc_q, nxt_byte);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mfm decoder from the write pair
	logic half_end, t_in, sync_hit, byte_end, rx_push, rx_pop, rx_mark;
	logic [7:0] rx_d;
	logic [2:0] nidx;
	logic [15:0] crc_new;
	assign trans = wg & pin_q[P_WDP] & ~pin_q[P_WDN] & ~wd_prev_q;
	assign half_end = dec_cnt_q == HW'(HALF_CYC_P - 1);
	assign t_in = trans | t_hold_q;
	assign raw_n = {raw_q[14:0], t_in};
	assign sync_hit = raw_n == SYNC_MFM;
	assign byte_end = half_end & (rx_st_q == RX_FRAME) & (rx_hx_q == 4'hF);
	assign rx_push = half_end & wg & (sync_hit | byte_end);
	assign rx_mark = sync_hit;
	assign rx_d = hdmfm_data(raw_n);
	assign nidx = rx_mark ? 3'h0 : ((rx_idx_q == ID_END) ? ID_END : rx_idx_q + 3'h1);
	assign crc_new = hdmfm_crc(rx_mark ? CRC_INIT : rx_crc_q, rx_d);
	assign rx_pop = fire & ~pwrite & (paddr == A_RXD);

	// a transition reloads the half-cell timer to half its count so speed drift is absorbed
	// a half cell must span two clocks or more, one-clock pulses do not pass the pin filter
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wd_prev_q <= 1'b0;
			dec_cnt_q <= '0;
			t_hold_q <= 1'b0;
			raw_q <= '0;
		end else begin
			wd_prev_q <= pin_q[P_WDP] & ~pin_q[P_WDN];
			if (half_end) begin
				dec_cnt_q <= '0;
				t_hold_q <= 1'b0;
				raw_q <= wg ? raw_n : 16'h0000;
			end else begin
				dec_cnt_q <= trans ? HW'(HALF_CYC_P / 2) : dec_cnt_q + HW'(1);
				t_hold_q <= t_hold_q | trans;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_st_q <= RX_HUNT;
			rx_hx_q <= 4'h0;
		end else if (!wg) begin
			rx_st_q <= RX_HUNT;
			rx_hx_q <= 4'h0;
		end else if (half_end) begin
			case (rx_st_q)
				RX_HUNT: begin
					rx_st_q <= sync_hit ? RX_FRAME : RX_HUNT;
					rx_hx_q <= 4'h0;
				end
				RX_FRAME: rx_hx_q <= sync_hit ? 4'h0 : rx_hx_q + 4'h1;
				default: rx_st_q <= RX_HUNT;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_byte_q <= '0;
			rx_idx_q <= ID_END;
			rx_crc_q <= CRC_INIT;
			dec_prev_q <= 1'b0;
		end else if (rx_push) begin
			rx_byte_q <= {rx_mark, rx_d};
			rx_idx_q <= nidx;
			rx_crc_q <= crc_new;
			dec_prev_q <= rx_d[0];
		end
	end

	// flags: hardware set wins over the clear in the same cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_val_q <= 1'b0;
			rx_ovr_q <= 1'b0;
			mfm_err_q <= 1'b0;
		end else begin
			rx_val_q <= rx_push | (rx_val_q & ~rx_pop);
			rx_ovr_q <= (rx_push & rx_val_q & ~rx_pop) | (rx_ovr_q & ~fclr);
			mfm_err_q <= (rx_push & ~rx_mark & (raw_n != hdmfm_enc(rx_d, dec_prev_q, 1'b0))) | (mfm_err_q & ~fclr);
		end
	end

	// id field capture and check against the current head position
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			id_fe_q <= 1'b0;
			id_sh_q <= '0;
			id_ok_q <= 1'b0;
			id_match_q <= 1'b0;
		end else if (rx_push) begin
			if (nidx == ID_FE) begin
				id_fe_q <= rx_d == ID_MARK;
			end
			if (nidx >= ID_FIRST && nidx <= ID_LASTF && id_fe_q) begin
				id_sh_q <= {id_sh_q[23:0], rx_d};
			end
			if (nidx == ID_END && rx_idx_q != ID_END && id_fe_q) begin
				id_ok_q <= crc_new == 16'h0000;
				id_match_q <= (crc_new == 16'h0000) & (id_sh_q[31:16] == {7'h00, cyl_q})
					& (id_sh_q[15:8] == {5'h00, head});
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule : hdmfm_drive

// *** test/hdmfm_ctrl_model.sv ***
// controller-side model: control pins, write pair driver, read pair capture
`timescale 1ns/1ns
module hdmfm_ctrl_model import hdmfm_pkg::*; #(
	parameter int HALF_CLK = 1
) (
	// clock
	input wire logic sys_clk,
	// control pins, active low
	output logic wr_gate_n,
	output logic [2:0] head_sel_n,
	output logic step_n,
	output logic dir_in_n,
	output logic [3:0] drv_sel_in_n,
	// mfm pairs
	output logic wr_data_p,
	output logic wr_data_n,
	input wire logic rd_data_p
);
	logic [15:0] rd_sh_q;
	logic rd_seen_q = 1'b0;
	int rd_ph_q = 0;

	initial begin
		wr_gate_n = 1'h1;
		head_sel_n = 3'h7;
		step_n = 1'h1;
		dir_in_n = 1'h1;
		drv_sel_in_n = 4'hF;
		wr_data_p = 1'h0;
		wr_data_n = 1'h1;
	end

	// last sixteen half cells seen on the read pair, any pulse within a half-cell window counts once
	always_ff @(posedge sys_clk) begin
		if (rd_ph_q == HALF_CLK - 1) begin
			rd_ph_q <= 0;
			rd_seen_q <= 1'b0;
			rd_sh_q <= {rd_sh_q[14:0], rd_seen_q | rd_data_p};
		end else begin
			rd_ph_q <= rd_ph_q + 1;
			rd_seen_q <= rd_seen_q | rd_data_p;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// half cells of one byte, clock half first
	function automatic logic [15:0] mk(input logic [7:0] d, input logic prev);
		logic [15:0] h;
		logic l;
		l = prev;
		for (int i = 7; i >= 0; i--) begin
			h[2*i+1] = ~d[i] & ~l;
			h[2*i] = d[i];
			l = d[i];
		end
		return h;
	endfunction : mk

	task automatic pins(input logic gate_n, input logic [3:0] sel_n);
		@(posedge sys_clk);
		wr_gate_n <= gate_n;
		drv_sel_in_n <= sel_n;
	endtask : pins

	// step pulse held long enough for the pin synchroniser
	task automatic step(input logic dn);
		@(posedge sys_clk);
		dir_in_n <= dn;
		repeat (4) @(posedge sys_clk);
		step_n <= 1'h0;
		repeat (4) @(posedge sys_clk);
		step_n <= 1'h1;
	endtask : step

	// one half cell per HALF_CLK clocks, pair idles with no transition
	// only low cylinders are used here, so no bit needs precompensation and all go out on time
	task automatic send(input logic [31:0] h);
		for (int i = 31; i >= 0; i--) begin
			@(posedge sys_clk);
			wr_data_p <= h[i];
			wr_data_n <= ~h[i];
			repeat (HALF_CLK - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		wr_data_p <= 1'h0;
		wr_data_n <= 1'h1;
	endtask : send
endmodule : hdmfm_ctrl_model

// *** test/hdmfm_drive_asserts.sv ***
// port assertions for the drive-side disk interface
`timescale 1ns/1ns
module hdmfm_drive_asserts import hdmfm_pkg::*; #(
	parameter int REV_CYC_P = REV_CYC,
	parameter int SETTLE_CYC_P = SETTLE_CYC,
	parameter int HALF_CYC_P = HALF_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// control and status pins
	input wire logic step_n,
	input wire logic dir_in_n,
	input wire logic seek_cmpl_n,
	input wire logic track0_n,
	input wire logic wr_fault_n,
	input wire logic index_n,
	input wire logic ready_n,
	input wire logic drv_selected_n,
	// read pair
	input wire logic rd_data_p,
	input wire logic rd_data_n
);
	logic [11:0] lo_cnt_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	// length of the current index pulse
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lo_cnt_q <= 12'h000;
		end else begin
			lo_cnt_q <= index_n ? 12'h000 : lo_cnt_q + 12'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_rd_pair_compl: assert property (rd_data_n == ~rd_data_p)
		else $error("read pair not complementary");
	a_rd_no_adjacent: assert property (rd_data_p |=> !rd_data_p)
		else $error("two adjacent half cells both carry a transition");
	a_unsel_status: assert property (drv_selected_n |-> &{seek_cmpl_n, track0_n, wr_fault_n, index_n, ready_n})
		else $error("status asserted while not selected");
	a_pready_one: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_pready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_index_width: assert property (lo_cnt_q <= INDEX_CYC)
		else $error("index pulse too long");
	a_step_seek: assert property ($fell(step_n) && !drv_selected_n && !dir_in_n |-> ##[2:8] seek_cmpl_n)
		else $error("seek complete not dropped after step");
	a_seek_settle: assert property ($rose(seek_cmpl_n) && !drv_selected_n |=> (seek_cmpl_n || drv_selected_n)[*8])
		else $error("seek complete returned too early");
endmodule : hdmfm_drive_asserts

bind hdmfm_drive hdmfm_drive_asserts #(.REV_CYC_P(REV_CYC_P), .SETTLE_CYC_P(SETTLE_CYC_P), .HALF_CYC_P(HALF_CYC_P))
	u_hdmfm_drive_asserts (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .step_n(step_n), .dir_in_n(dir_in_n), .seek_cmpl_n(seek_cmpl_n), .track0_n(track0_n),
	.wr_fault_n(wr_fault_n), .index_n(index_n), .ready_n(ready_n), .drv_selected_n(drv_selected_n),
	.rd_data_p(rd_data_p), .rd_data_n(rd_data_n));

// *** test/hdmfm_drive_tb_top.sv ***
// bench: register table, pins, index timing and both mfm paths
`timescale 1ns/1ns
module hdmfm_drive_tb_top import hdmfm_pkg::*;;
	localparam int REV_T = 3000;
	localparam int SETTLE_T = 20;
	// two clocks per half cell so write pair pulses pass the pin filter
	localparam int HALF_T = 2;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] wd; logic [31:0] exp; logic er;} hdmfm_row_t;
	hdmfm_row_t rows [7] = '{'{1'h0, A_CTRL, 32'h0, CTRL_RST, 1'h0}, '{1'h1, A_CTRL, 32'h19, 32'h0, 1'h0},
		'{1'h0, A_CTRL, 32'h0, 32'h9, 1'h0}, '{1'h0, 8'h1C, 32'h0, 32'h0, 1'h1},
		'{1'h1, 8'h1C, 32'hFFFFFFFF, 32'h0, 1'h1}, '{1'h1, A_POS, 32'hFFFFFFFF, 32'h0, 1'h0},
		'{1'h0, A_POS, 32'h0, 32'h0, 1'h0}};
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic wr_gate_n, step_n, dir_in_n, wr_data_p, wr_data_n, rd_data_p, rd_data_n;
	logic [2:0] head_sel_n;
	logic [3:0] drv_sel_in_n;
	logic seek_cmpl_n, track0_n, wr_fault_n, index_n, ready_n, drv_selected_n;
	int err_count;
	int checks_done;

	hdmfm_drive #(.REV_CYC_P(REV_T), .SETTLE_CYC_P(SETTLE_T), .HALF_CYC_P(HALF_T)) u_hdmfm_drive (
		.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_gate_n(wr_gate_n),
		.head_sel_n(head_sel_n), .step_n(step_n), .dir_in_n(dir_in_n), .drv_sel_in_n(drv_sel_in_n),
		.seek_cmpl_n(seek_cmpl_n), .track0_n(track0_n), .wr_fault_n(wr_fault_n), .index_n(index_n),
		.ready_n(ready_n), .drv_selected_n(drv_selected_n), .wr_data_p(wr_data_p), .wr_data_n(wr_data_n),
		.rd_data_p(rd_data_p), .rd_data_n(rd_data_n));
	hdmfm_ctrl_model #(.HALF_CLK(HALF_T)) u_hdmfm_ctrl_model (.sys_clk(sys_clk), .wr_gate_n(wr_gate_n),
		.head_sel_n(head_sel_n),
		.step_n(step_n), .dir_in_n(dir_in_n), .drv_sel_in_n(drv_sel_in_n), .wr_data_p(wr_data_p),
		.wr_data_n(wr_data_n), .rd_data_p(rd_data_p));

	always #50 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// setup, access, then hold until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 100) err_count++;
	endtask : apb

	task automatic until_lvl(input logic v, output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (index_n !== v && n < 10000);
	endtask : until_lvl

	task automatic give_verdict;
		$display("mismatches %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////
	initial begin
		#(40000 * 100);
		err_count++;
		give_verdict();
	end

	initial begin
		logic [31:0] d;
		logic e;
		int n;
		int m;
		err_count = 0;
		checks_done = 0;
		sys_clk = 1'h0;
		rstn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge sys_clk);
		chk(drv_selected_n, 32'h1);
		chk(rd_data_n, 32'h1);
		rstn <= 1'h1;
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].wd, d, e);
			chk(e, rows[i].er);
			if (!rows[i].wr) chk(d, rows[i].exp);
		end
		u_hdmfm_ctrl_model.pins(1'h1, 4'hB);
		repeat (8) @(posedge sys_clk);
		chk(drv_selected_n, 32'h0);
		chk(track0_n, 32'h0);
		chk(ready_n, 32'h0);
		chk(seek_cmpl_n, 32'h0);
		u_hdmfm_ctrl_model.step(1'h0);
		repeat (6) @(posedge sys_clk);
		chk(seek_cmpl_n, 32'h1);
		repeat (30) @(posedge sys_clk);
		chk(seek_cmpl_n, 32'h0);
		chk(track0_n, 32'h1);
		apb(1'h0, A_POS, 32'h0, d, e);
		chk(d, 32'h1);
		u_hdmfm_ctrl_model.step(1'h1);
		repeat (36) @(posedge sys_clk);
		chk(track0_n, 32'h0);
		until_lvl(1'h1, n);
		until_lvl(1'h0, n);
		until_lvl(1'h1, n);
		chk(n, INDEX_CYC);
		until_lvl(1'h0, m);
		chk(n + m, REV_T);
		// write gate while not ready sets a sticky fault
		apb(1'h1, A_CTRL, 32'h8, d, e);
		u_hdmfm_ctrl_model.pins(1'h0, 4'hB);
		repeat (8) @(posedge sys_clk);
		chk(wr_fault_n, 32'h0);
		chk(ready_n, 32'h1);
		u_hdmfm_ctrl_model.pins(1'h1, 4'hB);
		repeat (8) @(posedge sys_clk);
		apb(1'h1, A_CTRL, 32'h19, d, e);
		repeat (4) @(posedge sys_clk);
		chk(wr_fault_n, 32'h1);
		// write pair: sync mark, then one data byte
		u_hdmfm_ctrl_model.pins(1'h0, 4'hB);
		repeat (8) @(posedge sys_clk);
		fork
			u_hdmfm_ctrl_model.send({SYNC_MFM, u_hdmfm_ctrl_model.mk(8'h5A, 1'h1)});
			begin
				repeat (44) @(posedge sys_clk);
				apb(1'h0, A_RXD, 32'h0, d, e);
				chk(d, {22'h0, 2'h3, MARK_BYTE});
			end
		join
		repeat (8) @(posedge sys_clk);
		apb(1'h0, A_RXD, 32'h0, d, e);
		chk(d, 32'h25A);
		u_hdmfm_ctrl_model.pins(1'h1, 4'hB);
		chk(wr_fault_n, 32'h1);
		// read pair: fill the buffer, then let the encoder drain it
		apb(1'h1, A_TXD, 32'(MARK_BYTE) | (32'h1 << TX_MARK), d, e);
		apb(1'h1, A_TXD, 32'h5A, d, e);
		apb(1'h0, A_STAT, 32'h0, d, e);
		chk(d[4], 32'h1);
		apb(1'h1, A_CTRL, 32'hB, d, e);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (u_hdmfm_ctrl_model.rd_sh_q !== SYNC_MFM && n < 200);
		repeat (16 * HALF_T) @(posedge sys_clk);
		chk(u_hdmfm_ctrl_model.rd_sh_q, u_hdmfm_ctrl_model.mk(8'h5A, 1'h1));
		repeat (40) @(posedge sys_clk);
		apb(1'h0, A_STAT, 32'h0, d, e);
		chk(d[4], 32'h0);
		give_verdict();
	end
endmodule : hdmfm_drive_tb_top
